/* rtl/asp_ctrl.sv */
/*
 controller for a byte-wide asynchronous static memory: takes read and write requests
 and sequences select, output enable, write strobe, address and byte lines.
 assumes the memory obeys its own select and enable delays; byte lines return
 through a two flip-flop synchroniser before use.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl (
	// clock and control
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	// request side
	input  wire logic                       req_valid,
	output logic                            req_ready,
	input  wire asp_pkg::asp_req_s          req,
	// answer side
	output logic                            rd_valid,
	output logic      [asp_pkg::DATA_W-1:0] rd_data,
	output logic                            wr_done,
	// retention side
	input  wire logic                       retain_req,
	output logic                            retain_ok,
	// memory pins
	output asp_pkg::asp_pins_s              pins,
	input  wire logic [asp_pkg::DATA_W-1:0] byte_lines_i,
	output logic      [asp_pkg::DATA_W-1:0] byte_lines_o,
	output logic                            byte_lines_oe
);

	// ==========================================================
	// state
	asp_pkg::asp_state_e        state;
	asp_pkg::asp_state_e        next_state;
	logic [asp_pkg::CNT_W-1:0]  cnt;
	logic [asp_pkg::CNT_W-1:0]  next_cnt;
	asp_pkg::asp_pins_s         next_pins;
	logic [asp_pkg::DATA_W-1:0] next_byte_lines_o;
	logic                       next_byte_lines_oe;
	logic                       next_rd_valid;
	logic [asp_pkg::DATA_W-1:0] next_rd_data;
	logic                       next_wr_done;
	logic                       next_retain_ok;
	logic [asp_pkg::DATA_W-1:0] byte_sync;

	// ==========================================================
	// input synchroniser
	asp_sync u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.din      (byte_lines_i),
		.dout     (byte_sync)
	);

	function automatic logic cnt_done(input logic [asp_pkg::CNT_W-1:0] c);
		return c <= asp_pkg::CNT_ONE;
	endfunction

	// requests taken only when idle, enabled and not retaining; a grant still
	// standing from the previous cycle also blocks, so no take overlaps it
	always_comb begin
		req_ready = clk_en && (state == asp_pkg::ST_IDLE) && !retain_req && !retain_ok;
	end

	// ==========================================================
	// sequencer
	always_comb begin
		next_state         = state;
		next_cnt           = cnt;
		next_pins          = pins;
		next_byte_lines_o  = byte_lines_o;
		next_byte_lines_oe = byte_lines_oe;
		next_rd_valid      = 1'b0;
		next_rd_data       = rd_data;
		next_wr_done       = 1'b0;
		next_retain_ok     = retain_ok;
		unique case (state)
			asp_pkg::ST_IDLE: begin
				// idle: deselected, enable and strobe high, bus released
				next_pins.sel_n    = 1'b1;
				next_pins.oe_n     = 1'b1;
				next_pins.we_n     = 1'b1;
				next_byte_lines_oe = 1'b0;
				// retention granted only while deselected
				next_retain_ok     = retain_req && pins.sel_n;
				if (req_valid && req_ready) begin
					next_retain_ok              = 1'b0;
					// address presented with select, never mid-strobe
					next_pins.word_select_lines = req.addr;
					next_pins.sel_n             = 1'b0;
					if (req.write) begin
						// enable high so the memory is already floated
						next_byte_lines_o = req.wdata;
						next_state        = asp_pkg::ST_WR_SETUP;
					end else begin
						next_pins.oe_n = 1'b0;
						next_cnt       = asp_pkg::RD_WAIT;
						next_state     = asp_pkg::ST_RD_WAIT;
					end
				end
			end
			asp_pkg::ST_RD_WAIT: begin
				if (cnt_done(cnt)) begin
					next_rd_data   = byte_sync;
					next_rd_valid  = 1'b1;
					next_pins.oe_n = 1'b1;
					next_pins.sel_n = 1'b1;
					next_cnt       = asp_pkg::TURN;
					next_state     = asp_pkg::ST_TURN;
				end else begin
					next_cnt = cnt - asp_pkg::CNT_ONE;
				end
			end
			asp_pkg::ST_WR_SETUP: begin
				// memory already off; drive data and open strobe on the same edge
				next_byte_lines_oe = 1'b1;
				next_pins.we_n     = 1'b0;
				next_cnt           = asp_pkg::WR_PULSE;
				next_state         = asp_pkg::ST_WR_PULSE;
			end
			asp_pkg::ST_WR_PULSE: begin
				if (cnt_done(cnt)) begin
					// strobe rise ends the write; data held past it
					next_pins.we_n = 1'b1;
					next_cnt       = asp_pkg::WR_HOLD;
					next_state     = asp_pkg::ST_WR_HOLD;
				end else begin
					next_cnt = cnt - asp_pkg::CNT_ONE;
				end
			end
			asp_pkg::ST_WR_HOLD: begin
				if (cnt_done(cnt)) begin
					next_byte_lines_oe = 1'b0;
					next_pins.sel_n    = 1'b1;
					next_wr_done       = 1'b1;
					next_cnt           = asp_pkg::CNT_ZERO;
					next_state         = asp_pkg::ST_IDLE;
				end else begin
					next_cnt = cnt - asp_pkg::CNT_ONE;
				end
			end
			asp_pkg::ST_TURN: begin
				// wait for memory drivers to turn off before anything drives
				if (cnt_done(cnt)) begin
					next_cnt   = asp_pkg::CNT_ZERO;
					next_state = asp_pkg::ST_IDLE;
				end else begin
					next_cnt = cnt - asp_pkg::CNT_ONE;
				end
			end
			default: begin
				next_state = asp_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state         <= asp_pkg::ST_IDLE;
			cnt           <= asp_pkg::CNT_ZERO;
			pins          <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, word_select_lines: '0};
			byte_lines_o  <= '0;
			byte_lines_oe <= 1'b0;
			rd_valid      <= 1'b0;
			rd_data       <= '0;
			wr_done       <= 1'b0;
			retain_ok     <= 1'b0;
		end else if (clk_en) begin
			state         <= next_state;
			cnt           <= next_cnt;
			pins          <= next_pins;
			byte_lines_o  <= next_byte_lines_o;
			byte_lines_oe <= next_byte_lines_oe;
			rd_valid      <= next_rd_valid;
			rd_data       <= next_rd_data;
			wr_done       <= next_wr_done;
			retain_ok     <= next_retain_ok;
		end
	end

endmodule
`default_nettype wire

/* rtl/asp_pkg.sv */
/*
 constants and carriers for the byte-wide asynchronous static memory controller.
 assumes a 40 MHz core clock and an external memory that follows its documented edge timing.
*/
package asp_pkg;

	// ==========================================================
	// widths
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;

	// ==========================================================
	// clock
	localparam int CLK_PERIOD_PS = 25000;

	// ==========================================================
	// timing in picoseconds, as printed in ns
	localparam int READ_CYCLE_PS     = 12000;
	localparam int ADDR_TO_DATA_PS   = 12000;
	localparam int DATA_KEEP_PS      = 3000;
	localparam int SELECT_TO_DATA_PS = 12000;
	localparam int OE_TO_DATA_PS     = 6000;
	localparam int TURN_OFF_PS       = 6000;
	localparam int WRITE_CYCLE_PS    = 12000;
	localparam int WDATA_SETUP_PS    = 8000;
	localparam int WDATA_HOLD_PS     = 6000;
	localparam int STROBE_PULSE_PS   = 8000;
	localparam int ADDR_SETUP_PS     = 8000;

	// ==========================================================
	// derived cycle counts: minimums round up, at least one cycle
	function automatic int cyc_up(input int ps);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RD_ACCESS_PS  = (SELECT_TO_DATA_PS > READ_CYCLE_PS) ?
		SELECT_TO_DATA_PS : READ_CYCLE_PS;
	// read wait: access delay plus two cycles for the input synchroniser
	localparam int RD_WAIT_CYC   = cyc_up(RD_ACCESS_PS) + 2;
	localparam int WR_PULSE_PS   = ((TURN_OFF_PS + WDATA_SETUP_PS) > STROBE_PULSE_PS) ?
		(TURN_OFF_PS + WDATA_SETUP_PS) : STROBE_PULSE_PS;
	localparam int WR_PULSE_CYC  = cyc_up(WR_PULSE_PS);
	localparam int WR_HOLD_CYC   = cyc_up(WDATA_HOLD_PS);
	localparam int TURN_CYC      = cyc_up(TURN_OFF_PS);
	localparam int CNT_W         = 4;

	localparam logic [CNT_W-1:0] RD_WAIT  = CNT_W'(RD_WAIT_CYC);
	localparam logic [CNT_W-1:0] WR_PULSE = CNT_W'(WR_PULSE_CYC);
	localparam logic [CNT_W-1:0] WR_HOLD  = CNT_W'(WR_HOLD_CYC);
	localparam logic [CNT_W-1:0] TURN     = CNT_W'(TURN_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asp_req_s;

	typedef struct packed {
		logic              sel_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] word_select_lines;
	} asp_pins_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_TURN
	} asp_state_e;

endpackage

/* rtl/asp_sync.sv */
/*
 two flip-flop synchroniser for the byte lines coming back from the memory.
 assumes core_clk; the first stage is read by the second only.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_sync (
	// clock and control
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	// data
	input  wire logic [asp_pkg::DATA_W-1:0] din,
	output logic      [asp_pkg::DATA_W-1:0] dout
);

	logic [asp_pkg::DATA_W-1:0] stage1;
	logic [asp_pkg::DATA_W-1:0] next_stage1;
	logic [asp_pkg::DATA_W-1:0] next_dout;

	always_comb begin
		next_stage1 = clk_en ? din : stage1;
		next_dout   = clk_en ? stage1 : dout;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= next_stage1;
			dout   <= next_dout;
		end
	end

endmodule
`default_nettype wire

/* testbench/asp_ctrl_chk.sv */
/*
 assertions on the request timing and memory pins of asp_ctrl.
 assumes nothing moves while clk_en is low, so checks pause then.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl_chk (
	// clock and reset
	input wire logic               core_clk,
	input wire logic               rst_n,
	input wire logic               clk_en,
	// requests and answers
	input wire logic               req_valid,
	input wire logic               req_ready,
	input wire asp_pkg::asp_req_s  req,
	input wire logic               rd_valid,
	input wire logic               wr_done,
	input wire logic               retain_ok,
	// memory pins
	input wire asp_pkg::asp_pins_s pins,
	input wire logic [7:0]         byte_lines_o,
	input wire logic               byte_lines_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n || !clk_en);
	// ==========================================================
	// steps of a transfer
	sequence take_rd; req_valid && req_ready && !req.write; endsequence
	sequence take_wr; req_valid && req_ready && req.write; endsequence
	sequence rd_walk; !pins.sel_n && !pins.oe_n ##3 rd_valid; endsequence
	sequence wr_walk; pins.we_n ##1 !pins.we_n ##1 pins.we_n ##1 wr_done; endsequence
	// ==========================================================
	// properties
	a_no_bus_clash: assert property (byte_lines_oe |-> pins.oe_n)
		else $error("bus driven by both sides");
	a_strobe_in_select: assert property (!pins.we_n |-> !pins.sel_n && byte_lines_oe)
		else $error("strobe outside select");
	a_read_decode: assert property (!pins.oe_n |-> !pins.sel_n && pins.we_n)
		else $error("bad read decode");
	a_read_timing: assert property (take_rd |=> rd_walk)
		else $error("read walk wrong");
	a_write_timing: assert property (take_wr |=> wr_walk)
		else $error("write walk wrong");
	a_data_hold: assert property ($rose(pins.we_n) |-> byte_lines_oe && $stable(byte_lines_o))
		else $error("write data not held");
	a_select_setup: assert property ($rose(pins.we_n) |-> $past(!pins.sel_n, 2) && $past(byte_lines_oe))
		else $error("select or data too late");
	a_addr_stable: assert property (!pins.sel_n && $past(!pins.sel_n) |-> $stable(pins.word_select_lines))
		else $error("address moved in cycle");
	a_retain_idle: assert property (retain_ok |-> pins.sel_n && !req_ready)
		else $error("retention while selected");
endmodule
bind asp_ctrl asp_ctrl_chk u_chk (.*);
`default_nettype wire

/* testbench/asp_mem.sv */
/*
 behavioural byte-wide static memory.
 assumes the bench resolves the shared byte lines.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_mem (
	// memory pins
	input wire asp_pkg::asp_pins_s pins,
	input wire logic [7:0]         byte_lines,
	output logic [7:0]             dout,
	output logic                   dout_en
);
	logic [7:0] cells [logic [18:0]];
	logic [7:0] rd_q;
	// ==========================================================
	// write over the select and strobe overlap, enable ignored
	always @(pins or byte_lines) begin
		if (!pins.sel_n && !pins.we_n) begin
			cells[pins.word_select_lines] = byte_lines;
		end
	end
	// ==========================================================
	// read path; drivers off at once when deselected
	assign dout_en = !pins.sel_n && !pins.oe_n && pins.we_n;
	always @(pins or byte_lines) begin
		rd_q = cells.exists(pins.word_select_lines) ? cells[pins.word_select_lines] : 8'h00;
	end
	assign #6 dout = rd_q;
endmodule
`default_nettype wire

/* testbench/tb_async_sram_byte_port.sv */
/*
 testbench for asp_ctrl against a behavioural memory.
 assumes a 40 MHz clock; clk_en held high except in the clock enable test.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_byte_port;
	logic core_clk, rst_n, req_valid, req_ready, rd_valid, wr_done, retain_req, retain_ok, oe, men;
	logic ce;
	logic [7:0] rd_data, bo, md, bus;
	logic [7:0] last = 8'h00;
	asp_pkg::asp_req_s req;
	asp_pkg::asp_pins_s pins;
	int err_total, samples_checked;
	// undriven lines show the inverse of their last value
	assign bus = (oe === 1'b1) ? bo : ((men === 1'b1) ? md : ~last);
	always @(posedge core_clk) last <= bus;
	asp_ctrl u_asp_ctrl (.core_clk(core_clk), .rst_n(rst_n), .clk_en(ce),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_valid(rd_valid),
		.rd_data(rd_data), .wr_done(wr_done), .retain_req(retain_req), .retain_ok(retain_ok),
		.pins(pins), .byte_lines_i(bus), .byte_lines_o(bo), .byte_lines_oe(oe));
	asp_mem u_asp_mem (.pins(pins), .byte_lines(bus), .dout(md), .dout_en(men));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// ==========================================================
	// helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [18:0] a, input logic [7:0] d, input logic [7:0] e);
		int n;
		int exp_n;
		req_valid <= 1'b1;
		req <= '{w, a, d};
		do @(posedge core_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rd_valid !== 1'b1 && wr_done !== 1'b1 && n < 9);
		// edges from take to the answer being seen: setup, pulse, hold, answer for a write; read wait, answer for a read
		exp_n = w ? (asp_pkg::WR_PULSE_CYC + asp_pkg::WR_HOLD_CYC + 2) : (asp_pkg::RD_WAIT_CYC + 1);
		chk(8'(n), 8'(exp_n));
		if (!w) chk(rd_data, e);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_rw();
		logic [18:0] ad [3];
		logic [7:0] dt [3];
		ad = '{19'h00000, 19'h7ffff, 19'h12345};
		dt = '{8'h3c, 8'hff, 8'ha5};
		for (int i = 0; i < 3; i++) xfer(1'b1, ad[i], dt[i], 8'h00);
		for (int i = 0; i < 3; i++) xfer(1'b0, ad[i], 8'h00, dt[i]);
		xfer(1'b1, 19'h12345, 8'h5a, 8'h00);
		xfer(1'b0, 19'h12345, 8'h00, 8'h5a);
		chk({5'h00, pins.sel_n, oe, men}, 8'h04);
		$display("read write test done");
	endtask
	task automatic t_retain();
		retain_req <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({5'h00, retain_ok, req_ready, pins.sel_n}, 8'h05);
		retain_req <= 1'b0;
		@(posedge core_clk);
		xfer(1'b0, 19'h7ffff, 8'h00, 8'hff);
		$display("retention test done");
	endtask
	task automatic t_freeze();
		ce <= 1'b0;
		retain_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk({6'h00, retain_ok, pins.sel_n}, 8'h01);
		ce <= 1'b1;
		retain_req <= 1'b0;
		@(posedge core_clk);
		xfer(1'b0, 19'h00000, 8'h00, 8'h3c);
		$display("clock enable test done");
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		retain_req = 1'b0;
		req = '0;
		ce = 1'b1;
		err_total = 0;
		samples_checked = 0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_rw();
		t_retain();
		t_freeze();
		stop_test();
	end
	initial begin
		repeat (2000) @(posedge core_clk);
		err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
